//--- serial_link_tx_map.svh
`ifndef SERIAL_LINK_TX_MAP_SVH
`define SERIAL_LINK_TX_MAP_SVH

// ------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------
`define LINK_CTRL4_IDX 12'h574
`define LMFC_OFFSET_IDX 12'h578
`define DEVICE_ID_IDX 12'h580
`define BANK_ID_IDX 12'h581
`define LANE0_ID_IDX 12'h583
`define LANE1_ID_IDX 12'h585
`define SCR_LANES_IDX 12'h58B
`define LINK_STATUS_IDX 12'h590

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define START_DELAY_HI 7
`define START_DELAY_LO 4
`define TEST_MODE_HI 2
`define TEST_MODE_LO 0
`define SCR_EN_BIT 7

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define START_DELAY_RST 4'h0
`define TEST_MODE_RST 3'h0
`define LMFC_OFFSET_RST 5'h00
`define DEVICE_ID_RST 8'h00
`define BANK_ID_RST 4'h0
`define LANE0_ID_RST 5'h00
`define LANE1_ID_RST 5'h02
`define SCR_EN_RST 1'h1
`define LANES_FIELD 5'h01
`define SCR_SEED 15'h7FFF

// ------------------------------------------------------------
// Link timing and characters
// ------------------------------------------------------------
`define LMFC_LAST 5'h1F
`define ILAS_LAST_MF 2'h3
`define CHAR_K28_5 8'hBC
`define CHAR_K28_0 8'h1C
`define CHAR_K28_3 8'h7C
`define CHAR_K28_4 8'h9C
`define CHAR_D21_5 8'hB5
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- serial_link_tx_pkg.sv
package serial_link_tx_pkg;

    typedef enum logic [1:0] {
        ST_SYNC = 2'h0,
        ST_WAIT = 2'h1,
        ST_ILAS = 2'h3,
        ST_DATA = 2'h2
    } link_state_e;

    typedef enum logic [2:0] {
        TM_NORMAL = 3'h0,
        TM_D21_5 = 3'h1,
        TM_RPAT = 3'h4,
        TM_JSPAT = 3'h5,
        TM_JTSPAT = 3'h6
    } test_mode_e;

    typedef struct packed {
        logic [4:0] phase;
    } lmfc_s;

    typedef struct packed {
        logic sync_q1;
        logic sync_q2;
        logic sysref_q1;
        logic sysref_q2;
        logic sysref_d;
        link_state_e state;
        logic [3:0] wait_cnt;
        logic [1:0] mf_cnt;
        logic [3:0] start_delay;
        logic [2:0] test_mode;
        logic [4:0] lmfc_offset;
        logic [7:0] device_id;
        logic [3:0] bank_id;
        logic [4:0] lane0_id;
        logic [4:0] lane1_id;
        logic scr_en;
        logic aw_held;
        logic [11:0] aw_idx;
        logic w_held;
        logic [7:0] w_byte;
        logic w_strb0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [7:0] rbyte;
        logic [1:0] rresp;
        logic [14:0] scr0;
        logic [14:0] scr1;
        logic [7:0] lane0_octet;
        logic [7:0] lane1_octet;
        logic lane0_is_k;
        logic lane1_is_k;
        logic [2:0] pattern_sel;
    } tx_state_s;

endpackage

//--- lmfc_counter.sv
`timescale 1ns/1ns
`default_nettype none
`include "serial_link_tx_map.svh"

module lmfc_counter (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic reload,
    input wire logic [4:0] offset,
    output logic [4:0] phase,
    output logic boundary
);

    serial_link_tx_pkg::lmfc_s r;
    serial_link_tx_pkg::lmfc_s nxt;

    always_comb begin
        nxt = r;
        if (reload) begin
            nxt.phase = offset;
        end else begin
            nxt.phase = r.phase + 5'h01;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r.phase <= 5'h00;
        end else begin
            r <= nxt;
        end
    end

    assign phase = r.phase;
    // Last frame of the multiframe; the next edge is the boundary
    assign boundary = (r.phase == `LMFC_LAST);

endmodule

`default_nettype wire

//--- serial_link_tx_config.sv
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "serial_link_tx_map.svh"

// Contract
// - Start-delay codes 8 to 15 start alignment on the ninth to sixteenth boundary.
// - Start delay sits in control bits 7:4; codes 0-7 pick boundaries one to eight.
// - Test mode field bits 2:0 resets to 000, meaning normal traffic.
// - Test code 001 sends continuous D21.5 data on every lane.
// - Test codes 100, 101, 110 select modified RPAT, JSPAT, JTSPAT.
// - Each SYSREF rising edge reloads the multiframe phase counter with the offset.
// - Eight-bit device identifier, writable, resets to zero, sent on the link.
// - Four-bit bank identifier in low bits, writable, resets to zero.
// - Five-bit lane zero identifier, writable, resets to zero.
// - Five-bit lane one identifier, writable, resets to two.
// - Scrambling register bit 7 enables scrambling, resets to one.
module serial_link_tx_config (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [13:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [13:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sync_request_input_n,
    input wire logic sysref,
    input wire logic [7:0] lane0_data,
    input wire logic [7:0] lane1_data,
    output logic [7:0] lane0_octet,
    output logic lane0_is_k,
    output logic [7:0] lane1_octet,
    output logic lane1_is_k,
    output logic [2:0] test_pattern_sel,
    output logic [1:0] link_state,
    output logic [4:0] lmfc_phase
);

    serial_link_tx_pkg::tx_state_s r;
    serial_link_tx_pkg::tx_state_s nxt;

    logic [4:0] phase;
    logic boundary;
    logic sysref_edge;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    function automatic logic reg_hit(input logic [11:0] idx);
        case (idx)
            `LINK_CTRL4_IDX,
            `LMFC_OFFSET_IDX,
            `DEVICE_ID_IDX,
            `BANK_ID_IDX,
            `LANE0_ID_IDX,
            `LANE1_ID_IDX,
            `SCR_LANES_IDX,
            `LINK_STATUS_IDX: reg_hit = 1'b1;
            default: reg_hit = 1'b0;
        endcase
    endfunction

    // Self-synchronous 1 + x^14 + x^15, msb first; returns {state, octet}
    function automatic logic [22:0] scramble(
        input logic [14:0] seed,
        input logic [7:0] din
    );
        logic [14:0] s;
        logic [7:0] o;
        logic b;
        s = seed;
        o = 8'h00;
        b = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            b = din[i] ^ s[14] ^ s[13];
            s = {s[13:0], b};
            o[i] = b;
        end
        scramble = {s, o};
    endfunction

    // Alignment octet for one lane: {is_k, octet}
    function automatic logic [8:0] ilas_octet(
        input logic [4:0] pos,
        input logic [1:0] mf,
        input logic [7:0] did,
        input logic [3:0] bid,
        input logic [4:0] lid,
        input logic scr
    );
        if (pos == 5'h00) begin
            ilas_octet = {1'b1, `CHAR_K28_0};
        end else if (pos == `LMFC_LAST) begin
            ilas_octet = {1'b1, `CHAR_K28_3};
        end else if (mf == 2'h1 && pos == 5'h01) begin
            ilas_octet = {1'b1, `CHAR_K28_4};
        end else if (mf == 2'h1 && pos == 5'h02) begin
            ilas_octet = {1'b0, did};
        end else if (mf == 2'h1 && pos == 5'h03) begin
            ilas_octet = {1'b0, 4'h0, bid};
        end else if (mf == 2'h1 && pos == 5'h04) begin
            ilas_octet = {1'b0, 3'h0, lid};
        end else if (mf == 2'h1 && pos == 5'h05) begin
            ilas_octet = {1'b0, scr, 2'h0, `LANES_FIELD};
        end else begin
            ilas_octet = {1'b0, 3'h0, pos};
        end
    endfunction

    // Reserved codes fall back to normal traffic
    function automatic logic [2:0] legal_mode(input logic [2:0] code);
        case (code)
            serial_link_tx_pkg::TM_D21_5,
            serial_link_tx_pkg::TM_RPAT,
            serial_link_tx_pkg::TM_JSPAT,
            serial_link_tx_pkg::TM_JTSPAT: legal_mode = code;
            default: legal_mode = serial_link_tx_pkg::TM_NORMAL;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Multiframe phase counter
    // ------------------------------------------------------------

    assign sysref_edge = r.sysref_q2 && !r.sysref_d;

    lmfc_counter u_lmfc (
        .aclk(aclk),
        .aresetn(aresetn),
        .reload(sysref_edge),
        .offset(r.lmfc_offset),
        .phase(phase),
        .boundary(boundary)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------

    always_comb begin
        logic [11:0] ridx;
        logic [7:0] rb;
        logic [8:0] il0;
        logic [8:0] il1;
        logic [22:0] sc0;
        logic [22:0] sc1;
        logic [2:0] mode;
        ridx = s_axi_araddr[13:2];
        rb = 8'h00;
        il0 = 9'h000;
        il1 = 9'h000;
        sc0 = 23'h000000;
        sc1 = 23'h000000;
        mode = legal_mode(r.test_mode);
        nxt = r;

        // Pin synchronisers
        nxt.sync_q1 = sync_request_input_n;
        nxt.sync_q2 = r.sync_q1;
        nxt.sysref_q1 = sysref;
        nxt.sysref_q2 = r.sysref_q1;
        nxt.sysref_d = r.sysref_q2;

        // Write address and data, taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            nxt.aw_held = 1'b1;
            nxt.aw_idx = s_axi_awaddr[13:2];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt.w_held = 1'b1;
            nxt.w_byte = s_axi_wdata[7:0];
            nxt.w_strb0 = s_axi_wstrb[0];
        end
        if (r.aw_held && r.w_held) begin
            nxt.aw_held = 1'b0;
            nxt.w_held = 1'b0;
            nxt.bvalid = 1'b1;
            nxt.bresp = reg_hit(r.aw_idx) ? `RESP_OKAY : `RESP_SLVERR;
            if (r.w_strb0) begin
                case (r.aw_idx)
                    `LINK_CTRL4_IDX: begin
                        nxt.start_delay = r.w_byte[`START_DELAY_HI:`START_DELAY_LO];
                        nxt.test_mode = r.w_byte[`TEST_MODE_HI:`TEST_MODE_LO];
                    end
                    `LMFC_OFFSET_IDX: nxt.lmfc_offset = r.w_byte[4:0];
                    `DEVICE_ID_IDX: nxt.device_id = r.w_byte;
                    `BANK_ID_IDX: nxt.bank_id = r.w_byte[3:0];
                    `LANE0_ID_IDX: nxt.lane0_id = r.w_byte[4:0];
                    `LANE1_ID_IDX: nxt.lane1_id = r.w_byte[4:0];
                    `SCR_LANES_IDX: nxt.scr_en = r.w_byte[`SCR_EN_BIT];
                    default: ;
                endcase
            end
        end
        if (r.bvalid && s_axi_bready) begin
            nxt.bvalid = 1'b0;
        end

        // Read channel
        if (s_axi_arvalid && s_axi_arready) begin
            case (ridx)
                `LINK_CTRL4_IDX: rb = {r.start_delay, 1'b0, r.test_mode};
                `LMFC_OFFSET_IDX: rb = {3'h0, r.lmfc_offset};
                `DEVICE_ID_IDX: rb = r.device_id;
                `BANK_ID_IDX: rb = {4'h0, r.bank_id};
                `LANE0_ID_IDX: rb = {3'h0, r.lane0_id};
                `LANE1_ID_IDX: rb = {3'h0, r.lane1_id};
                `SCR_LANES_IDX: rb = {r.scr_en, 2'h0, `LANES_FIELD};
                `LINK_STATUS_IDX: rb = {1'b0, r.state, phase};
                default: rb = 8'h00;
            endcase
            nxt.rvalid = 1'b1;
            nxt.rbyte = rb;
            nxt.rresp = reg_hit(ridx) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (r.rvalid && s_axi_rready) begin
            nxt.rvalid = 1'b0;
        end

        // Link sequencing
        case (r.state)
            serial_link_tx_pkg::ST_SYNC: begin
                if (r.sync_q2) begin
                    nxt.state = serial_link_tx_pkg::ST_WAIT;
                    nxt.wait_cnt = r.start_delay;
                end
            end
            serial_link_tx_pkg::ST_WAIT: begin
                if (boundary) begin
                    if (r.wait_cnt == 4'h0) begin
                        nxt.state = serial_link_tx_pkg::ST_ILAS;
                        nxt.mf_cnt = 2'h0;
                    end else begin
                        nxt.wait_cnt = r.wait_cnt - 4'h1;
                    end
                end
            end
            serial_link_tx_pkg::ST_ILAS: begin
                if (boundary) begin
                    if (r.mf_cnt == `ILAS_LAST_MF) begin
                        nxt.state = serial_link_tx_pkg::ST_DATA;
                        nxt.scr0 = `SCR_SEED;
                        nxt.scr1 = `SCR_SEED;
                    end else begin
                        nxt.mf_cnt = r.mf_cnt + 2'h1;
                    end
                end
            end
            serial_link_tx_pkg::ST_DATA: ;
            default: nxt.state = serial_link_tx_pkg::ST_SYNC;
        endcase
        // A renewed sync request restarts alignment from any state
        if (!r.sync_q2) begin
            nxt.state = serial_link_tx_pkg::ST_SYNC;
        end

        // Lane octets
        il0 = ilas_octet(phase, r.mf_cnt, r.device_id, r.bank_id, r.lane0_id, r.scr_en);
        il1 = ilas_octet(phase, r.mf_cnt, r.device_id, r.bank_id, r.lane1_id, r.scr_en);
        sc0 = scramble(r.scr0, lane0_data);
        sc1 = scramble(r.scr1, lane1_data);
        case (r.state)
            serial_link_tx_pkg::ST_ILAS: begin
                {nxt.lane0_is_k, nxt.lane0_octet} = il0;
                {nxt.lane1_is_k, nxt.lane1_octet} = il1;
            end
            serial_link_tx_pkg::ST_DATA: begin
                nxt.lane0_is_k = 1'b0;
                nxt.lane1_is_k = 1'b0;
                if (r.scr_en) begin
                    nxt.lane0_octet = sc0[7:0];
                    nxt.lane1_octet = sc1[7:0];
                    nxt.scr0 = sc0[22:8];
                    nxt.scr1 = sc1[22:8];
                end else begin
                    nxt.lane0_octet = lane0_data;
                    nxt.lane1_octet = lane1_data;
                end
            end
            default: begin
                nxt.lane0_is_k = 1'b1;
                nxt.lane1_is_k = 1'b1;
                nxt.lane0_octet = `CHAR_K28_5;
                nxt.lane1_octet = `CHAR_K28_5;
            end
        endcase

        // Test characters override the link traffic on both lanes
        if (mode == serial_link_tx_pkg::TM_D21_5) begin
            nxt.lane0_is_k = 1'b0;
            nxt.lane1_is_k = 1'b0;
            nxt.lane0_octet = `CHAR_D21_5;
            nxt.lane1_octet = `CHAR_D21_5;
        end
        // The long patterns come from the pattern source downstream
        nxt.pattern_sel = mode;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r.sync_q1 <= 1'b0;
            r.sync_q2 <= 1'b0;
            r.sysref_q1 <= 1'b0;
            r.sysref_q2 <= 1'b0;
            r.sysref_d <= 1'b0;
            r.state <= serial_link_tx_pkg::ST_SYNC;
            r.wait_cnt <= 4'h0;
            r.mf_cnt <= 2'h0;
            r.start_delay <= `START_DELAY_RST;
            r.test_mode <= `TEST_MODE_RST;
            r.lmfc_offset <= `LMFC_OFFSET_RST;
            r.device_id <= `DEVICE_ID_RST;
            r.bank_id <= `BANK_ID_RST;
            r.lane0_id <= `LANE0_ID_RST;
            r.lane1_id <= `LANE1_ID_RST;
            r.scr_en <= `SCR_EN_RST;
            r.aw_held <= 1'b0;
            r.aw_idx <= 12'h000;
            r.w_held <= 1'b0;
            r.w_byte <= 8'h00;
            r.w_strb0 <= 1'b0;
            r.bvalid <= 1'b0;
            r.bresp <= 2'h0;
            r.rvalid <= 1'b0;
            r.rbyte <= 8'h00;
            r.rresp <= 2'h0;
            r.scr0 <= `SCR_SEED;
            r.scr1 <= `SCR_SEED;
            r.lane0_octet <= `CHAR_K28_5;
            r.lane1_octet <= `CHAR_K28_5;
            r.lane0_is_k <= 1'b1;
            r.lane1_is_k <= 1'b1;
            r.pattern_sel <= 3'h0;
        end else begin
            r <= nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------

    // Held beats block new ones until the response is consumed
    assign s_axi_awready = !r.aw_held && !r.bvalid;
    assign s_axi_wready = !r.w_held && !r.bvalid;
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_arready = !r.rvalid;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rdata = {24'h000000, r.rbyte};
    assign s_axi_rresp = r.rresp;

    assign lane0_octet = r.lane0_octet;
    assign lane1_octet = r.lane1_octet;
    assign lane0_is_k = r.lane0_is_k;
    assign lane1_is_k = r.lane1_is_k;
    assign test_pattern_sel = r.pattern_sel;
    assign link_state = r.state;
    assign lmfc_phase = phase;

endmodule

`default_nettype wire

//--- serial_link_tx_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module serial_link_tx_monitor (
    input wire logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
    input wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic [31:0] s_axi_rdata,
    input wire logic sync_request_input_n, sysref, lane0_is_k, lane1_is_k,
    input wire logic [7:0] lane0_octet, lane1_octet,
    input wire logic [2:0] test_pattern_sel,
    input wire logic [1:0] link_state,
    input wire logic [4:0] lmfc_phase
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ------------------------------
    // Bus handshakes
    // ------------------------------
    sequence wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    wr_resp_a: assert property (wr_both |=> ##1 s_axi_bvalid) else $error("late bresp");
    rd_resp_a: assert property (rd_taken |=> s_axi_rvalid) else $error("late rvalid");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("bresp dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("rdata dropped");
    r_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 && !s_axi_arready)
        else $error("bad rdata");
    w_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write not refused");
    // ------------------------------
    // Link behaviour
    // ------------------------------
    sequence sync_held;
        !sync_request_input_n [*3];
    endsequence
    sequence quiet_ref;
        !sysref [*6];
    endsequence
    test_d21_a: assert property ((test_pattern_sel == 3'h1) [*2] |-> lane0_octet == 8'hB5 && !lane0_is_k
        && lane1_octet == 8'hB5 && !lane1_is_k) else $error("bad D21.5");
    reserved_hide_a: assert property (!(test_pattern_sel inside {3'h2, 3'h3, 3'h7}))
        else $error("reserved mode shown");
    idle_comma_a: assert property ((link_state inside {2'h0, 2'h1} && test_pattern_sel == 3'h0) [*2]
        |-> lane0_octet == 8'hBC && lane0_is_k && lane1_octet == 8'hBC && lane1_is_k) else $error("bad comma");
    phase_step_a: assert property (quiet_ref |=> lmfc_phase == $past(lmfc_phase) + 5'h01)
        else $error("phase skipped");
    sync_drop_a: assert property (sync_held |=> link_state == 2'h0) else $error("sync request ignored");
    ilas_phase_a: assert property (link_state == 2'h3 && $past(link_state) == 2'h1 |-> lmfc_phase == 5'h00)
        else $error("alignment off boundary");
endmodule
`default_nettype wire

//--- link_rx_model.sv
`timescale 1ns/1ns
`default_nettype none
module link_rx_model (
    input wire logic aclk, aresetn, want, fire, lane0_is_k,
    input wire logic [7:0] lane0_octet, lane1_octet,
    output logic sync_request_input_n, sysref,
    output logic [7:0] did_seen, bid_seen, lid0_seen, lid1_seen, cfg_seen
);
    logic [6:0] cnt;
    logic in_ilas;
    // ------------------------------
    // Receiver side
    // ------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_request_input_n <= 1'b0;
            sysref <= 1'b0;
            in_ilas <= 1'b0;
            cnt <= 7'h00;
        end else begin
            // Request held until the bench lets the link up
            sync_request_input_n <= want;
            sysref <= fire;
            if (!in_ilas && lane0_is_k && lane0_octet == 8'h1C) begin
                in_ilas <= 1'b1;
                cnt <= 7'h01;
            end else if (in_ilas) begin
                cnt <= cnt + 7'h01;
                // A cut sequence falls back to idle commas; rearm for the next one
                in_ilas <= cnt != 7'h7F && !(lane0_is_k && lane0_octet == 8'hBC);
                if (cnt == 7'h22) did_seen <= lane0_octet;
                if (cnt == 7'h23) bid_seen <= lane0_octet;
                if (cnt == 7'h24) {lid0_seen, lid1_seen} <= {lane0_octet, lane1_octet};
                if (cnt == 7'h25) cfg_seen <= lane0_octet;
            end
        end
    end
endmodule
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ns
`default_nettype none
`include "serial_link_tx_map.svh"
module testbench;
    logic aclk, aresetn, awv, awr, wv, wrdy, bv, bre, arv, arr, rv, rre, want, fire, sref, syn_n, k0, k1;
    logic [13:0] awa, ara;
    logic [31:0] wd, rd, seed, ls;
    logic [3:0] ws, dly;
    logic [1:0] br, rr, st, r2;
    logic [7:0] d0, d1, o0, o1, did_s, bid_s, l0_s, l1_s, cfg_s, v, prev;
    logic [2:0] tps;
    logic [4:0] ph;
    int mismatches, n_checks, nb, df;
    logic [11:0] idx_t [7] = '{`LINK_CTRL4_IDX, `LMFC_OFFSET_IDX, `DEVICE_ID_IDX, `BANK_ID_IDX,
        `LANE0_ID_IDX, `LANE1_ID_IDX, `SCR_LANES_IDX};
    logic [7:0] rst_t [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h81};
    logic [7:0] msk_t [7] = '{8'hF7, 8'h1F, 8'hFF, 8'h0F, 8'h1F, 8'h1F, 8'h80};
    logic [7:0] exp_t [7];
    logic [3:0] dl_t [4] = '{4'h0, 4'h7, 4'h8, 4'hF};
    serial_link_tx_config serial_link_tx_config_i (.aclk, .aresetn, .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
        .sync_request_input_n(syn_n), .sysref(sref), .lane0_data(d0), .lane1_data(d1), .lane0_octet(o0),
        .lane0_is_k(k0), .lane1_octet(o1), .lane1_is_k(k1), .test_pattern_sel(tps), .link_state(st),
        .lmfc_phase(ph));
    link_rx_model link_rx_model_i (.aclk, .aresetn, .want, .fire, .lane0_octet(o0), .lane0_is_k(k0),
        .lane1_octet(o1), .sync_request_input_n(syn_n), .sysref(sref), .did_seen(did_s), .bid_seen(bid_s),
        .lid0_seen(l0_s), .lid1_seen(l1_s), .cfg_seen(cfg_s));
    // ------------------------------
    // Helpers
    // ------------------------------
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    function automatic logic [2:0] tm_eff(input logic [2:0] c);
        return (c inside {3'h2, 3'h3, 3'h7}) ? 3'h0 : c;
    endfunction
    always @(posedge aclk) begin
        ls = xs(ls);
        {d1, d0} <= ls[15:0];
    end
    task end_sim;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task chk(input logic [31:0] g, e);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %0t got %h expected %h", $time, g, e);
        end
    endtask
    task tmo;
        mismatches++;
        $display("MISMATCH %0t wait ran out", $time);
        end_sim();
    endtask
    // Sample at negedge; release after the edge that took the item
    task wr(input logic [11:0] i, input logic [7:0] d, output logic [1:0] r);
        int t;
        logic a, w, b;
        b = 1'b0;
        @(posedge aclk);
        {awa, wd, ws, awv, wv, bre} <= {i, 2'h0, 24'h0, d, 4'hF, 3'h7};
        for (t = 0; t < 64 && !b; t++) begin
            @(negedge aclk);
            {a, w, b, r} = {awv && awr, wv && wrdy, bv, br};
            @(posedge aclk);
            {awv, wv, bre} <= {awv && !a, wv && !w, !b};
        end
        if (!b) tmo();
    endtask
    task rc(input logic [11:0] i, input logic [7:0] e, input logic [1:0] er);
        int t;
        logic a, b;
        logic [31:0] d;
        logic [1:0] r;
        b = 1'b0;
        @(posedge aclk);
        {ara, arv, rre} <= {i, 2'h0, 2'h3};
        for (t = 0; t < 64 && !b; t++) begin
            @(negedge aclk);
            {a, b, d, r} = {arv && arr, rv, rd, rr};
            @(posedge aclk);
            {arv, rre} <= {arv && !a, !b};
        end
        if (!b) tmo();
        chk(d, {24'h0, e});
        chk({30'h0, r}, {30'h0, er});
    endtask
    task wait_state(input logic [1:0] s);
        int t;
        nb = 0;
        for (t = 0; t < 1500; t++) begin
            @(negedge aclk);
            if (st == s) break;
            if (st == 2'h1 && ph == 5'h1F) nb++;
        end
        if (t == 1500) tmo();
    endtask
    // ------------------------------
    // Main sequence
    // ------------------------------
    initial begin
        seed = 32'd51412;
        ls = 32'd51412;
        {aresetn, awv, wv, bre, arv, rre, want, fire, awa, ara, wd, ws, d0, d1} = '0;
        mismatches = 0;
        n_checks = 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        for (int j = 0; j < 7; j++) rc(idx_t[j], rst_t[j], `RESP_OKAY);
        rc(12'h100, 8'h00, `RESP_SLVERR);
        wr(12'h100, 8'hFF, r2);
        chk({30'h0, r2}, {30'h0, `RESP_SLVERR});
        for (int j = 0; j < 7; j++) begin
            seed = xs(seed);
            v = seed[7:0];
            exp_t[j] = (v & msk_t[j]) | (j == 6 ? 8'h01 : 8'h00);
            wr(idx_t[j], v, r2);
            rc(idx_t[j], exp_t[j], `RESP_OKAY);
        end
        $display("test register map done");
        for (int c = 0; c < 8; c++) begin
            wr(`LINK_CTRL4_IDX, {5'h00, c[2:0]}, r2);
            repeat (3) @(negedge aclk);
            chk({29'h0, tps}, {29'h0, tm_eff(c[2:0])});
            if (c == 1) chk({o0, k0, o1, k1}, {8'hB5, 1'b0, 8'hB5, 1'b0});
        end
        $display("test modes done");
        seed = xs(seed);
        wr(`LMFC_OFFSET_IDX, {3'h0, seed[4:0]}, r2);
        @(posedge aclk);
        fire <= 1'b1;
        @(posedge aclk);
        fire <= 1'b0;
        repeat (4) @(negedge aclk);
        chk({27'h0, ph}, {27'h0, seed[4:0]});
        $display("test reload done");
        wr(`SCR_LANES_IDX, 8'h80, r2);
        for (int j = 0; j < 5; j++) begin
            dly = j < 4 ? dl_t[j] : seed[11:8];
            wr(`LINK_CTRL4_IDX, {dly, 4'h0}, r2);
            @(posedge aclk);
            want <= 1'b0;
            repeat (8) @(posedge aclk);
            want <= 1'b1;
            wait_state(2'h3);
            chk(nb, dly + 1);
        end
        wait_state(2'h2);
        chk({did_s, bid_s, l0_s, l1_s}, {exp_t[2], exp_t[3], exp_t[4], exp_t[5]});
        chk({24'h0, cfg_s}, 32'h81);
        df = 0;
        for (int t = 0; t < 33; t++) begin
            @(negedge aclk);
            if (t > 0 && o0 != prev) df++;
            prev = d0;
        end
        chk(df > 0, 1);
        wr(`SCR_LANES_IDX, 8'h00, r2);
        repeat (2) @(posedge aclk);
        for (int t = 0; t < 17; t++) begin
            @(negedge aclk);
            if (t > 0) chk({24'h0, o0}, {24'h0, prev});
            prev = d0;
        end
        @(posedge aclk);
        want <= 1'b0;
        wait_state(2'h0);
        $display("test link done");
        end_sim();
    end
endmodule
bind serial_link_tx_config serial_link_tx_monitor serial_link_tx_monitor_i (.*);
`default_nettype wire
